// [hw/pmu_reg_bank.sv]
// Summary of operation
// - six-bit voltage code, upper two bits reserved
// - enable bit turns channel seven on/off
// - discharge output while channel shut down
// - bit five selects low-quiescent mode
// - three-bit turn-on delay code for sequencing
// - fault allow bit gates channel fault interrupts
// - power-good bit reads live regulator status
// - suspend bit halts charging, clear resumes
// - two-bit total-charge timeout select
// - two-bit precondition timeout select
// - two-bit input over-voltage threshold select
// - timeout arm plus enable gives expiry interrupt
// - temperature arm plus enables gives interrupt
// - input arm plus enables gives interrupt
// - charge-done arm plus enables gives interrupt
// - timer level bit shows either timeout
// - marked charger bits valid inside input window
// - eight per-event enables pair with status
module pmu_reg_bank (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire pmu_regs_pkg::analog_status_type analog_status,
   output logic [5:0] ldo7_voltage_code,
   output pmu_regs_pkg::ldo_drive_type ldo7_drive,
   output pmu_regs_pkg::ldo_drive_type ldo6_drive,
   output pmu_regs_pkg::charger_drive_type charger_drive,
   output logic irq_request
);

   pmu_regs_pkg::analog_status_type stat_s; // synchronised analog levels
   pmu_regs_pkg::analog_status_type stat_prev_reg; // last cycle, for edges

   logic [5:0] vcode7_reg; // channel seven voltage code
   logic [7:1] ldo7_ctrl_reg; // channel seven control, bit 0 is status
   logic [7:1] ldo6_ctrl_reg; // channel six control
   logic [7:0] chg_rsvd_reg; // reserved but read/write
   logic [7:0] chg_ctrl_reg; // charger control incl. reserved bit 6
   logic [3:0] arm_reg; // interrupt arm written through status bits
   logic [3:0] pending_reg; // sticky interrupt status per category
   logic [3:0] pending_next;
   logic [3:0] event_set; // category events this cycle
   logic [7:0] irq_en_reg; // per-event enables
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic irq_reg;
   logic in_window; // charger input between lockout and over-voltage
   logic timer_level;
   logic fault_irq;

   // write strobes per register, and the status read strobe
   logic wr_vcode7;
   logic wr_ctrl7;
   logic wr_ctrl6;
   logic wr_rsvd;
   logic wr_chg;
   logic wr_stat;
   logic wr_en;
   logic rd_stat;

   // analog levels cross into ref_clk here
   level_sync #(
      .WIDTH($bits(pmu_regs_pkg::analog_status_type))
   ) u_status_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .async_in(analog_status),
      .sync_out(stat_s)
   );

   // address decode
   always_comb begin
      wr_vcode7 = 1'b0;
      wr_ctrl7 = 1'b0;
      wr_ctrl6 = 1'b0;
      wr_rsvd = 1'b0;
      wr_chg = 1'b0;
      wr_stat = 1'b0;
      wr_en = 1'b0;
      if (reg_addr == pmu_regs_pkg::LDO7_VOLTAGE_ADDR) begin
         wr_vcode7 = reg_write;
      end else if (reg_addr == pmu_regs_pkg::LDO7_CONTROL_ADDR) begin
         wr_ctrl7 = reg_write;
      end else if (reg_addr == pmu_regs_pkg::LDO6_CONTROL_ADDR) begin
         wr_ctrl6 = reg_write;
      end else if (reg_addr == pmu_regs_pkg::CHARGER_RSVD_ADDR) begin
         wr_rsvd = reg_write;
      end else if (reg_addr == pmu_regs_pkg::CHARGER_CONTROL_ADDR) begin
         wr_chg = reg_write;
      end else if (reg_addr == pmu_regs_pkg::CHARGER_STATUS_ADDR) begin
         wr_stat = reg_write;
      end else if (reg_addr == pmu_regs_pkg::CHARGER_IRQ_EN_ADDR) begin
         wr_en = reg_write;
      end
   end

   // a status read clears all the pending flags, including those read as zero outside the window
   assign rd_stat = reg_read &&
      (reg_addr == pmu_regs_pkg::CHARGER_STATUS_ADDR);

   assign in_window = stat_s.input_in_window;
   assign timer_level = stat_s.precondition_timeout |
      stat_s.total_timeout;

   // regulator channel registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         vcode7_reg <= pmu_regs_pkg::VCODE_RESET;
         ldo7_ctrl_reg <= pmu_regs_pkg::LDO_CONTROL_RESET[7:1];
         ldo6_ctrl_reg <= pmu_regs_pkg::LDO_CONTROL_RESET[7:1];
      end else begin
         if (wr_vcode7) begin
            // upper two bits are reserved and never stored
            vcode7_reg <= reg_wdata[pmu_regs_pkg::VCODE_MSB:0];
         end
         if (wr_ctrl7) begin
            // on, discharge, low-iq, delay, fault allow
            ldo7_ctrl_reg <= reg_wdata[7:1];
         end
         if (wr_ctrl6) begin
            ldo6_ctrl_reg <= reg_wdata[7:1];
         end
      end
   end

   // charger control and reserved registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         chg_rsvd_reg <= pmu_regs_pkg::CHARGER_RSVD_RESET;
         chg_ctrl_reg <= pmu_regs_pkg::CHARGER_CONTROL_RESET;
      end else begin
         if (wr_rsvd) begin
            chg_rsvd_reg <= reg_wdata;
         end
         if (wr_chg) begin
            chg_ctrl_reg <= reg_wdata;
         end
      end
   end

   // interrupt arm and per-event enables
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         arm_reg <= pmu_regs_pkg::STATUS_ARM_RESET;
         irq_en_reg <= pmu_regs_pkg::IRQ_EN_RESET;
      end else begin
         if (wr_stat) begin
            arm_reg <= reg_wdata[7:pmu_regs_pkg::STAT_ARM_LSB];
         end
         if (wr_en) begin
            irq_en_reg <= reg_wdata;
         end
      end
   end

   // edge history of the synchronised levels
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_prev_reg <= '0;
      end else begin
         stat_prev_reg <= stat_s;
      end
   end

   // category events; marked sources only count inside the window
   always_comb begin
      event_set[pmu_regs_pkg::STAT_TIMEOUT] =
         arm_reg[pmu_regs_pkg::STAT_TIMEOUT] && in_window &&
         ((stat_s.precondition_timeout &&
           !stat_prev_reg.precondition_timeout &&
           irq_en_reg[pmu_regs_pkg::EN_PRE_BIT]) ||
          (stat_s.total_timeout && !stat_prev_reg.total_timeout &&
           irq_en_reg[pmu_regs_pkg::EN_TOTAL_BIT]));
      event_set[pmu_regs_pkg::STAT_TEMP] =
         arm_reg[pmu_regs_pkg::STAT_TEMP] && in_window &&
         ((stat_s.temperature_ok && !stat_prev_reg.temperature_ok &&
           irq_en_reg[pmu_regs_pkg::EN_TEMP_IN_BIT]) ||
          (!stat_s.temperature_ok && stat_prev_reg.temperature_ok &&
           irq_en_reg[pmu_regs_pkg::EN_TEMP_OUT_BIT]));
      // input events are how the window itself is left, so no gating
      event_set[pmu_regs_pkg::STAT_INPUT] =
         arm_reg[pmu_regs_pkg::STAT_INPUT] &&
         ((stat_s.input_present && !stat_prev_reg.input_present &&
           irq_en_reg[pmu_regs_pkg::EN_INPUT_CONNECT_BIT]) ||
          (!stat_s.input_present && stat_prev_reg.input_present &&
           irq_en_reg[pmu_regs_pkg::EN_INPUT_DISCONNECT_BIT]));
      event_set[pmu_regs_pkg::STAT_CHARGE] =
         arm_reg[pmu_regs_pkg::STAT_CHARGE] && in_window &&
         ((stat_s.charge_done && !stat_prev_reg.charge_done &&
           irq_en_reg[pmu_regs_pkg::EN_DONE_IN_BIT]) ||
          (!stat_s.charge_done && stat_prev_reg.charge_done &&
           irq_en_reg[pmu_regs_pkg::EN_DONE_OUT_BIT]));
   end

   // sticky flags: a set in the clearing read's cycle survives it
   assign pending_next = (pending_reg & ~{4{rd_stat}}) | event_set;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pending_reg <= 4'h0;
      end else begin
         pending_reg <= pending_next;
      end
   end

   // channel faults only count where software allowed them
   assign fault_irq =
      (ldo7_ctrl_reg[pmu_regs_pkg::LDO_FAULT_ALLOW_BIT] &&
       stat_s.ldo7_fault) ||
      (ldo6_ctrl_reg[pmu_regs_pkg::LDO_FAULT_ALLOW_BIT] &&
       stat_s.ldo6_fault);

   // single interrupt request, registered so the pin never glitches
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= (|pending_reg) || fault_irq;
      end
   end

   // read mux; unmapped offsets answer zero
   always_comb begin
      rdata_next = 8'h00;
      if (reg_addr == pmu_regs_pkg::LDO7_VOLTAGE_ADDR) begin
         rdata_next = {2'b00, vcode7_reg};
      end else if (reg_addr == pmu_regs_pkg::LDO7_CONTROL_ADDR) begin
         rdata_next = {ldo7_ctrl_reg, stat_s.ldo7_power_good};
      end else if (reg_addr == pmu_regs_pkg::LDO6_CONTROL_ADDR) begin
         rdata_next = {ldo6_ctrl_reg, stat_s.ldo6_power_good};
      end else if (reg_addr == pmu_regs_pkg::CHARGER_RSVD_ADDR) begin
         rdata_next = chg_rsvd_reg;
      end else if (reg_addr == pmu_regs_pkg::CHARGER_CONTROL_ADDR) begin
         rdata_next = chg_ctrl_reg;
      end else if (reg_addr == pmu_regs_pkg::CHARGER_STATUS_ADDR) begin
         // marked bits read zero while the input is out of its window
         rdata_next = {pending_reg[3:2] & {2{in_window}}, pending_reg[1],
            pending_reg[0] && in_window, timer_level && in_window,
            stat_s.temperature_ok && in_window, stat_s.input_present,
            stat_s.charge_done && in_window};
      end else if (reg_addr == pmu_regs_pkg::CHARGER_IRQ_EN_ADDR) begin
         rdata_next = irq_en_reg;
      end
   end

   // read data captured on the read strobe, held until the next read
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 8'h00;
      end else if (reg_read) begin
         rdata_reg <= rdata_next;
      end
   end

   // outputs to the host and the analog side
   assign reg_rdata = rdata_reg;
   assign ldo7_voltage_code = vcode7_reg;
   assign ldo7_drive.enable = ldo7_ctrl_reg[pmu_regs_pkg::LDO_ON_BIT];
   // discharge only bites while the channel is off
   assign ldo7_drive.discharge_active =
      ldo7_ctrl_reg[pmu_regs_pkg::LDO_DISCHARGE_BIT] &&
      !ldo7_ctrl_reg[pmu_regs_pkg::LDO_ON_BIT];
   assign ldo7_drive.low_quiescent_mode =
      ldo7_ctrl_reg[pmu_regs_pkg::LDO_LOW_QUIESCENT_MODE_BIT];
   assign ldo7_drive.turn_on_delay = ldo7_ctrl_reg[
      pmu_regs_pkg::LDO_DELAY_MSB:pmu_regs_pkg::LDO_DELAY_LSB];
   assign ldo6_drive.enable = ldo6_ctrl_reg[pmu_regs_pkg::LDO_ON_BIT];
   assign ldo6_drive.discharge_active =
      ldo6_ctrl_reg[pmu_regs_pkg::LDO_DISCHARGE_BIT] &&
      !ldo6_ctrl_reg[pmu_regs_pkg::LDO_ON_BIT];
   assign ldo6_drive.low_quiescent_mode =
      ldo6_ctrl_reg[pmu_regs_pkg::LDO_LOW_QUIESCENT_MODE_BIT];
   assign ldo6_drive.turn_on_delay = ldo6_ctrl_reg[
      pmu_regs_pkg::LDO_DELAY_MSB:pmu_regs_pkg::LDO_DELAY_LSB];
   assign charger_drive.charge_suspend =
      chg_ctrl_reg[pmu_regs_pkg::CHG_SUSPEND_BIT];
   assign charger_drive.total_timeout_select = chg_ctrl_reg[
      pmu_regs_pkg::CHG_TOTAL_MSB:pmu_regs_pkg::CHG_TOTAL_LSB];
   assign charger_drive.precondition_timeout_select = chg_ctrl_reg[
      pmu_regs_pkg::CHG_PRE_MSB:pmu_regs_pkg::CHG_PRE_LSB];
   assign charger_drive.input_overvoltage_threshold = chg_ctrl_reg[
      pmu_regs_pkg::CHG_OVP_MSB:pmu_regs_pkg::CHG_OVP_LSB];
   assign irq_request = irq_reg;

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_vcode_write: assert property (
      wr_vcode7 |=> ldo7_voltage_code == $past(reg_wdata[5:0]))
      else $error("voltage code not stored");
   a_enable_write: assert property (
      wr_ctrl7 |=> ldo7_drive.enable == $past(reg_wdata[7]))
      else $error("enable bit not applied");
   a_discharge_off: assert property (
      wr_ctrl7 && reg_wdata[7:6] == 2'b01 |=> ldo7_drive.discharge_active)
      else $error("no discharge while shut down");
   a_low_quiescent_mode_write: assert property (
      wr_ctrl7 |=> ldo7_drive.low_quiescent_mode == $past(reg_wdata[5]))
      else $error("low quiescent mode not applied");
   a_delay_write: assert property (
      wr_ctrl7 |=> ldo7_drive.turn_on_delay == $past(reg_wdata[4:2]))
      else $error("turn-on delay not applied");
   a_fault_gate: assert property (
      !fault_irq && pending_reg == 4'h0 |=> !irq_request)
      else $error("interrupt without cause");
   a_power_good: assert property (
      reg_read && reg_addr == pmu_regs_pkg::LDO7_CONTROL_ADDR |=>
      reg_rdata[0] == $past(stat_s.ldo7_power_good))
      else $error("power good misread");
   a_charger_ctrl: assert property (
      wr_chg |=> charger_drive ==
      {$past(reg_wdata[7]), $past(reg_wdata[5:0])})
      else $error("charger control not applied");
   a_timeout_event: assert property (
      event_set[3] |=> pending_reg[3] ##1 irq_request)
      else $error("timeout event lost");
   a_timer_level: assert property (
      rd_stat |=> reg_rdata[3] == $past(timer_level && in_window))
      else $error("timer level misread");
   a_window_gate: assert property (
      !in_window && !pending_reg[2] |=> !pending_reg[2])
      else $error("temperature set outside window");
   a_irq_hold: assert property (
      pending_reg != 4'h0 && !rd_stat |=> irq_request [*2])
      else $error("interrupt dropped while pending");
   c_temp_event: cover property (event_set[2] ##1 irq_request);
   c_clear_read: cover property (pending_reg != 4'h0 ##1 rd_stat);
   c_fault_irq: cover property (fault_irq ##1 irq_request);

endmodule : pmu_reg_bank

// [hw/pmu_regs_pkg.sv]
package pmu_regs_pkg;

   // register offsets on the management port
   localparam logic [7:0] LDO6_CONTROL_ADDR = 8'h61;
   localparam logic [7:0] LDO7_VOLTAGE_ADDR = 8'h64;
   localparam logic [7:0] LDO7_CONTROL_ADDR = 8'h65;
   localparam logic [7:0] CHARGER_RSVD_ADDR = 8'h70;
   localparam logic [7:0] CHARGER_CONTROL_ADDR = 8'h71;
   localparam logic [7:0] CHARGER_STATUS_ADDR = 8'h78;
   localparam logic [7:0] CHARGER_IRQ_EN_ADDR = 8'h79;

   // regulator control field positions
   localparam int VCODE_MSB = 5;
   localparam int LDO_ON_BIT = 7;
   localparam int LDO_DISCHARGE_BIT = 6;
   localparam int LDO_LOW_QUIESCENT_MODE_BIT = 5;
   localparam int LDO_DELAY_MSB = 4;
   localparam int LDO_DELAY_LSB = 2;
   localparam int LDO_FAULT_ALLOW_BIT = 1;
   localparam int LDO_POWER_GOOD_BIT = 0;

   // charger control field positions
   localparam int CHG_SUSPEND_BIT = 7;
   localparam int CHG_TOTAL_MSB = 5;
   localparam int CHG_TOTAL_LSB = 4;
   localparam int CHG_PRE_MSB = 3;
   localparam int CHG_PRE_LSB = 2;
   localparam int CHG_OVP_MSB = 1;
   localparam int CHG_OVP_LSB = 0;

   // charger status: bits 7..4 are arm/interrupt-status, index k = bit 4+k
   localparam int STAT_ARM_LSB = 4;
   localparam int STAT_TIMEOUT = 3;
   localparam int STAT_TEMP = 2;
   localparam int STAT_INPUT = 1;
   localparam int STAT_CHARGE = 0;
   localparam int STAT_TIMER_LEVEL_BIT = 3;
   localparam int STAT_TEMP_LEVEL_BIT = 2;
   localparam int STAT_INPUT_LEVEL_BIT = 1;
   localparam int STAT_CHARGE_LEVEL_BIT = 0;

   // charger per-event enable positions
   localparam int EN_TOTAL_BIT = 7;
   localparam int EN_TEMP_IN_BIT = 6;
   localparam int EN_INPUT_CONNECT_BIT = 5;
   localparam int EN_DONE_IN_BIT = 4;
   localparam int EN_PRE_BIT = 3;
   localparam int EN_TEMP_OUT_BIT = 2;
   localparam int EN_INPUT_DISCONNECT_BIT = 1;
   localparam int EN_DONE_OUT_BIT = 0;

   // reset values
   localparam logic [5:0] VCODE_RESET = 6'h00;
   localparam logic [7:0] LDO_CONTROL_RESET = 8'h00;
   localparam logic [7:0] CHARGER_RSVD_RESET = 8'h00;
   localparam logic [7:0] CHARGER_CONTROL_RESET = 8'h00;
   localparam logic [3:0] STATUS_ARM_RESET = 4'h0;
   localparam logic [7:0] IRQ_EN_RESET = 8'h00;

   // drive to one regulator channel's analog core
   typedef struct packed {
      logic enable;
      logic discharge_active;
      logic low_quiescent_mode;
      logic [2:0] turn_on_delay;
   } ldo_drive_type;

   // drive to the charger core
   typedef struct packed {
      logic charge_suspend;
      logic [1:0] total_timeout_select;
      logic [1:0] precondition_timeout_select;
      logic [1:0] input_overvoltage_threshold;
   } charger_drive_type;

   // raw levels coming back from the analog side (asynchronous)
   typedef struct packed {
      logic ldo7_power_good;
      logic ldo7_fault;
      logic ldo6_power_good;
      logic ldo6_fault;
      logic precondition_timeout;
      logic total_timeout;
      logic temperature_ok;
      logic input_present;
      logic charge_done;
      logic input_in_window;
   } analog_status_type;

endpackage : pmu_regs_pkg

// [hw/level_sync.sv]
// three-stage synchroniser; output follows only when stages 2 and 3 agree
module level_sync #(
   parameter int WIDTH = 10
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   if (WIDTH < 1) begin : g_width_check
      $error("level_sync needs WIDTH of at least one");
   end

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1_reg; // metastable stage, read by stage2 only
      logic stage2_reg;
      logic stage3_reg;
      logic out_reg;

      // shift chain plus agreement filter
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
            out_reg <= 1'b0;
         end else begin
            stage1_reg <= async_in[i];
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            // a single-cycle glitch never makes 2 and 3 agree on it
            if (stage2_reg == stage3_reg) begin
               out_reg <= stage3_reg;
            end
         end
      end

      assign sync_out[i] = out_reg;
   end

endmodule : level_sync

// [tb/host_model.sv]
// host side of the management port: one request per task, strobes move
// only at the falling edge so the design samples settled values
module host_model (
   input wire logic ref_clk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_write,
   output logic reg_read,
   input wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle state at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end

   // one-cycle write pulse; address and data scrambled once released
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge ref_clk);
      reg_write = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : write_reg

   // one-cycle read pulse; data is registered, so take it a half cycle on
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_read = 1'b1;
      @(negedge ref_clk);
      d = reg_rdata;
      reg_read = 1'b0;
      reg_addr = ~a;
   endtask : read_reg
endmodule : host_model

// [tb/tb_top.sv]
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk; // 50 MHz system clock
   logic rst_n; // active low reset
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic reg_write, reg_read, irq_request;
   logic [5:0] ldo7_voltage_code;
   pmu_regs_pkg::analog_status_type ana; // levels from the analog side
   pmu_regs_pkg::ldo_drive_type ldo7_drive, ldo6_drive;
   pmu_regs_pkg::charger_drive_type charger_drive;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0; // cycle counter for the hang guard
   logic [7:0] rd; // last read value

   host_model host_i (.ref_clk(ref_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata));

   pmu_reg_bank pmu_reg_bank_i (.ref_clk(ref_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .analog_status(ana),
      .ldo7_voltage_code(ldo7_voltage_code), .ldo7_drive(ldo7_drive),
      .ldo6_drive(ldo6_drive), .charger_drive(charger_drive),
      .irq_request(irq_request));

   // clock generator
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // hang guard: whole run needs well under this many cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         stop_test();
      end
   end

   // single comparison point
   task automatic check(input logic [7:0] got, input logic [7:0] exp,
                        input string what);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what,
                  got, exp);
      end
   endtask : check

   // closing report
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test

   // synchroniser takes about 4 edges, pending and irq two more
   task automatic settle();
      repeat (8) @(negedge ref_clk);
   endtask : settle

   // state of drives and registers straight after reset
   task automatic test_reset();
      check({2'b00, ldo7_drive}, 8'h00, "reset drive");
      host_i.read_reg(8'h64, rd);
      check(rd, 8'h00, "reset vcode");
      host_i.read_reg(8'h71, rd);
      check(rd, 8'h00, "reset charger");
      $display("test reset done");
   endtask : test_reset

   // regulator registers: voltage code, control bits, power good
   task automatic test_ldo();
      host_i.write_reg(8'h64, 8'hff);
      host_i.read_reg(8'h64, rd);
      check(rd, 8'h3f, "vcode readback");
      check({2'b00, ldo7_voltage_code}, 8'h3f, "vcode out");
      host_i.write_reg(8'h65, 8'h80);
      check({2'b00, ldo7_drive}, 8'h20, "ldo on");
      host_i.write_reg(8'h65, 8'h7c);
      check({2'b00, ldo7_drive}, 8'h1f, "dis low_quiescent_mode delay");
      host_i.read_reg(8'h65, rd);
      check(rd, 8'h7d, "control with pg");
      host_i.write_reg(8'h61, 8'h80);
      check({2'b00, ldo6_drive}, 8'h20, "ldo6 on");
      host_i.write_reg(8'h55, 8'hff);
      host_i.read_reg(8'h55, rd);
      check(rd, 8'h00, "unmapped");
      $display("test ldo done");
   endtask : test_ldo

   // fault interrupt follows the allow bit
   task automatic test_fault();
      ana.ldo7_fault = 1'b1;
      settle();
      check({7'h0, irq_request}, 8'h00, "fault masked");
      host_i.write_reg(8'h65, 8'h02);
      repeat (2) @(negedge ref_clk);
      check({7'h0, irq_request}, 8'h01, "fault allowed");
      host_i.write_reg(8'h65, 8'h00);
      repeat (2) @(negedge ref_clk);
      check({7'h0, irq_request}, 8'h00, "fault cleared");
      ana.ldo7_fault = 1'b0;
      $display("test fault done");
   endtask : test_fault

   // charger control fields
   task automatic test_charger();
      host_i.write_reg(8'h71, 8'hf9);
      check({1'b0, charger_drive}, 8'h79, "drive");
      host_i.read_reg(8'h71, rd);
      check(rd, 8'hf9, "charger readback");
      host_i.write_reg(8'h71, 8'h00);
      check({1'b0, charger_drive}, 8'h00, "suspend off");
      $display("test charger done");
   endtask : test_charger

   // invert one analog level, expect irq, read and clear status
   task automatic event_check(input int idx, input logic [7:0] exp);
      ana[idx] = ~ana[idx];
      settle();
      check({7'h0, irq_request}, 8'h01, "event irq");
      host_i.read_reg(8'h78, rd);
      check(rd, exp, "event status");
      repeat (3) @(negedge ref_clk);
      check({7'h0, irq_request}, 8'h00, "irq after read");
   endtask : event_check

   // charger events: gating by enables and window, all four arms left set
   task automatic test_events();
      ana.input_in_window = 1'b1;
      host_i.write_reg(8'h78, 8'hf0);
      host_i.write_reg(8'h79, 8'h00);
      ana.precondition_timeout = 1'b1;
      settle();
      check({7'h0, irq_request}, 8'h00, "no enable no irq");
      host_i.read_reg(8'h78, rd);
      check(rd, 8'h08, "timer level only");
      ana.precondition_timeout = 1'b0;
      settle();
      host_i.write_reg(8'h79, 8'hff);
      host_i.read_reg(8'h79, rd);
      check(rd, 8'hff, "enable readback");
      event_check(4, 8'h88);
      event_check(3, 8'h4c);
      event_check(2, 8'h2e);
      event_check(1, 8'h1f);
      host_i.write_reg(8'h79, 8'h00);
      ana.input_in_window = 1'b0;
      settle();
      host_i.read_reg(8'h78, rd);
      check(rd, 8'h02, "outside window");
      ana.input_in_window = 1'b1;
      host_i.write_reg(8'h79, 8'h02);
      event_check(2, 8'h2d); // disconnect only
      host_i.write_reg(8'h79, 8'h0d); // exits and precondition only
      event_check(3, 8'h49); // temperature exit
      event_check(1, 8'h18); // end-of-charge exit
      event_check(5, 8'h88); // precondition timeout
      host_i.write_reg(8'h79, 8'hff);
      ana.input_in_window = 1'b0;
      settle();
      ana.temperature_ok = 1'b1; // entry, but outside the window
      settle();
      check({7'h0, irq_request}, 8'h00, "no event outside");
      $display("test events done");
   endtask : test_events

   // main sequence
   initial begin
      rst_n = 1'b0;
      ana = '0;
      ana.ldo7_power_good = 1'b1;
      repeat (4) @(negedge ref_clk);
      rst_n = 1'b1;
      test_reset();
      test_ldo();
      test_fault();
      test_charger();
      test_events();
      stop_test();
   end
endmodule : tb_top
